// file: dv/uspmc_mode_control_sva.sv
// checker: concurrent assertions on the mode control ports
`timescale 1ns/1ps
module uspmc_mode_control_sva
  import uspmc_pkg::*;
#(
  parameter int RESUME_CYCLES = 4
) (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire uspmc_pkg::uspmc_bus_t bus, // register bus
  input wire logic nvLoadValid, // image load pulse
  input wire uspmc_pkg::uspmc_nv_t nvStore, // image to persist
  input wire logic nvStoreReq, // store pulse
  input wire logic scanStart, // scan pulse
  input wire logic aimerOn, // aiming led
  input wire logic good_read_lamp_n, // good-read lamp
  input wire logic external_light_ctrl, // external light
  input wire logic low_power_indicator, // low power flag
  input wire logic usbFullSpeed, // full speed request
  input wire logic usbSerialActive, // serial function on
  input wire logic usbResume, // resume signalling
  input wire logic portPinnedActive // pinned port live
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] resCnt_r;
  // resume length held by parameter, so counted here rather than repeated
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resCnt_r <= '0;
    end else begin
      resCnt_r <= usbResume ? resCnt_r + 16'h0001 : '0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence selCmd;
    bus.wr && bus.addr == OFS_CMD && bus.wdata[7:0] == CMD_USB_SERIAL_SELECT && !nvLoadValid;
  endsequence
  // live copy moves one edge after an image load, two after a reboot write
  sequence rebootOrLoad;
    $past(nvLoadValid) ||
      $past(bus.wr && bus.addr == OFS_CTRL && bus.wdata[CTRL_REBOOT], 2);
  endsequence
  sel_store_a: assert property (selCmd |=> nvStoreReq && nvStore.ifMode == USPMC_IF_USB_SERIAL)
    else $error("select command not stored");
  sel_active_a: assert property (selCmd |=> ##1 usbSerialActive)
    else $error("select command did not activate serial");
  lamp_exclusive_a: assert property (!external_light_ctrl |-> good_read_lamp_n)
    else $error("lamp lit beside external light");
  full_speed_a: assert property (usbFullSpeed == usbSerialActive)
    else $error("full speed not tied to serial mode");
  pinned_late_a: assert property ($changed(portPinnedActive) |-> rebootOrLoad)
    else $error("pinned port changed without reboot");
  resume_len_a: assert property ($fell(usbResume) |-> resCnt_r == RESUME_CYCLES)
    else $error("resume length wrong");
  scan_pulse_a: assert property (scanStart |=> !scanStart)
    else $error("scan start longer than one cycle");
  low_power_aim_a: assert property (low_power_indicator && $past(low_power_indicator) |-> !aimerOn)
    else $error("aimer on in low power");
endmodule // uspmc_mode_control_sva

bind uspmc_mode_control uspmc_mode_control_sva #(.RESUME_CYCLES(RESUME_CYCLES)) chk (
  .clk, .rst_n, .bus, .nvLoadValid, .nvStore, .nvStoreReq, .scanStart, .aimerOn,
  .good_read_lamp_n, .external_light_ctrl, .low_power_indicator, .usbFullSpeed,
  .usbSerialActive, .usbResume, .portPinnedActive
);

// file: dv/uspmc_mode_control_test.sv
// testbench: register, command, sideband and suspend tests
`timescale 1ns/1ps
module uspmc_mode_control_test;
  import uspmc_pkg::*;
  logic clk, rst_n, nvLoadValid, menuCodeValid, goSuspend, scan_start_in_n, aimer_wake_in_n;
  logic nvStoreReq, scanStart, aimerOn, good_read_lamp_n, external_light_ctrl, beeper_drive_n;
  logic low_power_indicator, usbFullSpeed, usbSerialActive, usbResume, portPinnedActive;
  logic usbSuspend;
  logic [7:0] menuCode;
  logic [31:0] rdata, d;
  uspmc_bus_t bus;
  uspmc_nv_t nvLoad, nvStore;
  int badCount = 0;
  int checked = 0;
  int n;
  uspmc_mode_control #(.RESUME_CYCLES(4)) dut (.clk, .rst_n, .bus, .rdata, .nvLoad,
    .nvLoadValid, .nvStore, .nvStoreReq, .menuCodeValid, .menuCode, .scan_start_in_n,
    .aimer_wake_in_n, .usbSuspend, .scanStart, .aimerOn, .good_read_lamp_n,
    .external_light_ctrl, .beeper_drive_n, .low_power_indicator, .usbFullSpeed,
    .usbSerialActive, .usbResume, .portPinnedActive);
  uspmc_usb_host_model host (.clk, .rst_n, .goSuspend, .usbResume, .usbSuspend);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic menu(input logic [7:0] c);
    @(posedge clk);
    menuCode <= c;
    menuCodeValid <= 1'b1;
    @(posedge clk);
    menuCodeValid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #200000;
    badCount++;
    close_out();
  end
  initial begin
    {rst_n, nvLoadValid, menuCodeValid, goSuspend, menuCode, bus, nvLoad} = '0;
    scan_start_in_n = 1'b1;
    aimer_wake_in_n = 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_CTRL);
    chk("ctrl reset", 32'h00000040, d);
    rd(OFS_STATUS);
    chk("mode reset", 32'h00000000, {30'h0, d[3:2]});
    rd(8'h3C);
    chk("unmapped read", 32'h00000000, d);
    $display("test reset done");
    wr(OFS_CMD, {24'h0, CMD_USB_SERIAL_SELECT});
    repeat (2) @(posedge clk);
    chk("serial active", 1, usbSerialActive);
    chk("stored mode", USPMC_IF_USB_SERIAL, nvStore.ifMode);
    wr(OFS_CMD, {24'h0, CMD_UART_SELECT});
    repeat (2) @(posedge clk);
    chk("uart stored", USPMC_IF_UART, nvStore.ifMode);
    chk("uart serial off", 0, usbSerialActive);
    menu(CMD_KEYBOARD_SELECT);
    chk("menu keyboard", 0, usbSerialActive);
    menu(CMD_USB_SERIAL_SELECT);
    chk("menu serial", 1, usbSerialActive);
    $display("test select done");
    wr(OFS_CMD, {24'h0, CMD_PORT_PINNED});
    repeat (4) @(posedge clk);
    chk("pinned before reboot", 0, portPinnedActive);
    wr(OFS_CTRL, 32'h00000060);
    repeat (4) @(posedge clk);
    chk("pinned after reboot", 1, portPinnedActive);
    wr(OFS_CMD, {24'h0, CMD_PORT_FLOATING});
    wr(OFS_CTRL, 32'h00000060);
    repeat (4) @(posedge clk);
    chk("floating after reboot", 0, portPinnedActive);
    $display("test port number done");
    wr(OFS_CTRL, 32'h00000044);
    repeat (2) @(posedge clk);
    chk("lamp lit", 0, good_read_lamp_n);
    wr(OFS_CTRL, 32'h00000045);
    repeat (2) @(posedge clk);
    chk("lamp dark", 1, good_read_lamp_n);
    chk("light on", 0, external_light_ctrl);
    @(posedge clk) aimer_wake_in_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("aimer on", 1, aimerOn);
    @(posedge clk) aimer_wake_in_n <= 1'b1;
    wr(OFS_BEEP_PERIOD, 32'h0000000A);
    wr(OFS_BEEP_DUTY, 32'h00000003);
    wr(OFS_CTRL, 32'h00000042);
    repeat (20) @(posedge clk);
    n = 0;
    // four whole tone periods of eleven clocks, three low in each
    repeat (44) begin
      @(posedge clk);
      #1 n += int'(beeper_drive_n === 1'b0);
    end
    chk("beeper duty", 12, n);
    $display("test lamps and beeper done");
    wr(OFS_CTRL, 32'h00000050);
    repeat (6) @(posedge clk);
    chk("low power", 1, low_power_indicator);
    @(posedge clk) aimer_wake_in_n <= 1'b0;
    repeat (3) @(posedge clk);
    aimer_wake_in_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("woken", 0, low_power_indicator);
    rd(OFS_CTRL);
    chk("low power request dropped", 32'h00000040, d);
    @(posedge clk) goSuspend <= 1'b1;
    @(posedge clk) goSuspend <= 1'b0;
    repeat (3) @(posedge clk);
    chk("suspended", 1, low_power_indicator);
    aimer_wake_in_n <= 1'b0;
    n = 0;
    while (usbResume !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    chk("remote wakeup", 1, usbResume);
    @(posedge clk) aimer_wake_in_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk("resumed", 0, low_power_indicator);
    $display("test low power done");
    scan_start_in_n <= 1'b0;
    n = 0;
    repeat (6) begin
      @(posedge clk);
      #1 n += int'(scanStart === 1'b1);
    end
    chk("scan pulses", 1, n);
    @(posedge clk) scan_start_in_n <= 1'b1;
    @(posedge clk);
    nvLoad <= '{ifMode: USPMC_IF_UART, portPinned: 1'b1};
    nvLoadValid <= 1'b1;
    @(posedge clk) nvLoadValid <= 1'b0;
    repeat (3) @(posedge clk);
    chk("loaded mode", 0, usbSerialActive);
    chk("loaded pinned", 1, portPinnedActive);
    $display("test trigger and image done");
    close_out();
  end
endmodule // uspmc_mode_control_test

// file: dv/uspmc_usb_host_model.sv
// partner model: usb host that suspends the bus and honours remote wakeup
`timescale 1ns/1ps
module uspmc_usb_host_model (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic goSuspend, // pulse: suspend the bus
  input wire logic usbResume, // device resume signalling
  output logic usbSuspend // bus suspended
);
  // suspend stays until the device itself signals resume
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usbSuspend <= 1'b0;
    end else if (goSuspend) begin
      usbSuspend <= 1'b1;
    end else if (usbResume) begin
      usbSuspend <= 1'b0;
    end
  end
endmodule // uspmc_usb_host_model

// file: logic/uspmc_mode_control.sv
// top module: interface mode selection, usb link sideband, lamps and beeper
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - command or menu code selects usb serial
// - selection kept in persistent storage image
// - factory default is asynchronous serial interface
// - external light enabled disables good-read lamp
// - beeper driven active low by pwm
// - full speed usb, serial function class
// - remote wakeup enabled by default
// - commands float or pin port number
// - pinned setting applies only after reboot
module uspmc_mode_control #(
  parameter int RESUME_CYCLES = uspmc_pkg::RESUME_CYC
) (
  input wire logic clk, // 40 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire uspmc_pkg::uspmc_bus_t bus, // register bus request
  output logic [31:0] rdata, // read data, cycle after read strobe
  input wire uspmc_pkg::uspmc_nv_t nvLoad, // persistent image at power-up
  input wire logic nvLoadValid, // pulse: nvLoad is valid
  output uspmc_pkg::uspmc_nv_t nvStore, // image to persist
  output logic nvStoreReq, // pulse: write nvStore
  input wire logic menuCodeValid, // pulse: decoded menu symbol present
  input wire logic [7:0] menuCode, // decoded menu command code
  input wire logic scan_start_in_n, // trigger, active low
  input wire logic aimer_wake_in_n, // aim / wake, active low
  input wire logic usbSuspend, // host has suspended the bus
  output logic scanStart, // pulse: scan requested
  output logic aimerOn, // aiming led on
  output logic good_read_lamp_n, // good-read led, active low
  output logic external_light_ctrl, // external light, low = on
  output logic beeper_drive_n, // beeper pwm, active low
  output logic low_power_indicator, // high in low power state
  output logic usbFullSpeed, // full speed pull-up request
  output logic usbSerialActive, // usb serial function presented
  output logic usbResume, // remote wakeup signalling
  output logic portPinnedActive // pinned port in force
);
  import uspmc_pkg::*;

  logic [7:0] ctrl_r;
  uspmc_if_t ifMode_r;
  logic portPinned_r;
  logic portPinnedLive_r;
  logic [15:0] beepPeriod_r;
  logic [15:0] beepDuty_r;
  logic [15:0] beepCnt_r;
  uspmc_state_t state_r;
  logic [15:0] resumeCnt_r;
  logic trigPrev_r;
  logic nvStoreReq_r;
  logic [31:0] rdata_r;
  logic cmdValid;
  logic [7:0] cmdCode;
  logic wakeReq;

  // write strobe aimed at one register offset
  function automatic logic hit(input uspmc_bus_t b, input logic [7:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction

  // codes that change the persistent image; anything else is ignored
  function automatic logic storedCode(input logic [7:0] c);
    storedCode = (c == CMD_USB_SERIAL_SELECT) || (c == CMD_UART_SELECT) ||
                 (c == CMD_KEYBOARD_SELECT) || (c == CMD_PORT_FLOATING) ||
                 (c == CMD_PORT_PINNED);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // command source: register write or menu symbol; bus wins a clash
  always_comb begin
    cmdValid = hit(bus, OFS_CMD) || menuCodeValid;
    cmdCode = hit(bus, OFS_CMD) ? bus.wdata[7:0] : menuCode;
  end

  // either wake pin pulls the block out of low power, except while the bus is suspended with remote wakeup off
  always_comb begin
    wakeReq = !aimer_wake_in_n || !scan_start_in_n;
  end

  // active interface; the boot image outranks any command in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ifMode_r <= USPMC_IF_UART;
    end else if (nvLoadValid) begin
      ifMode_r <= nvLoad.ifMode;
    end else if (cmdValid) begin
      unique case (cmdCode)
        CMD_USB_SERIAL_SELECT: begin
          ifMode_r <= USPMC_IF_USB_SERIAL;
        end
        CMD_UART_SELECT: begin
          ifMode_r <= USPMC_IF_UART;
        end
        CMD_KEYBOARD_SELECT: begin
          ifMode_r <= USPMC_IF_KEYBOARD;
        end
        default: ;
      endcase
    end
  end

  // stored port-number choice; not in force until the next reboot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portPinned_r <= 1'b0;
    end else if (nvLoadValid) begin
      portPinned_r <= nvLoad.portPinned;
    end else if (cmdValid && cmdCode == CMD_PORT_FLOATING) begin
      portPinned_r <= 1'b0;
    end else if (cmdValid && cmdCode == CMD_PORT_PINNED) begin
      portPinned_r <= 1'b1;
    end
  end

  // every accepted setting command asks for the image to be written back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nvStoreReq_r <= 1'b0;
    end else begin
      nvStoreReq_r <= !nvLoadValid && cmdValid && storedCode(cmdCode);
    end
  end

  // pinned setting copied to the live copy only at reboot, never mid-session
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portPinnedLive_r <= 1'b0;
    end else if (nvLoadValid) begin
      portPinnedLive_r <= nvLoad.portPinned;
    end else if (ctrl_r[CTRL_REBOOT]) begin
      portPinnedLive_r <= portPinned_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and beeper registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET;
    end else begin
      if (hit(bus, OFS_CTRL)) begin
        ctrl_r <= bus.wdata[7:0];
      end else begin
        ctrl_r[CTRL_REBOOT] <= 1'b0; // reboot request is self-clearing
        // a wake also drops the software request, else the block re-enters at once
        if (state_r == USPMC_ST_LOW_POWER && wakeReq) begin
          ctrl_r[CTRL_LOW_POWER] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beepPeriod_r <= BEEP_PERIOD_RESET;
      beepDuty_r <= BEEP_DUTY_RESET;
    end else begin
      if (hit(bus, OFS_BEEP_PERIOD)) begin
        beepPeriod_r <= bus.wdata[15:0];
      end
      if (hit(bus, OFS_BEEP_DUTY)) begin
        beepDuty_r <= bus.wdata[15:0];
      end
    end
  end

  // period sets tone: one cycle of the tone lasts period plus one clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beepCnt_r <= 16'h0000;
    end else begin
      if (!ctrl_r[CTRL_BEEP_EN] || beepCnt_r >= beepPeriod_r) begin
        beepCnt_r <= 16'h0000;
      end else begin
        beepCnt_r <= beepCnt_r + 16'h0001;
      end
    end
  end

  // duty sets loudness; pin idles high so the beeper stays quiet when off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beeper_drive_n <= 1'b1;
    end else begin
      beeper_drive_n <= !(ctrl_r[CTRL_BEEP_EN] && beepCnt_r < beepDuty_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low power, wake and remote wakeup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= USPMC_ST_RUN;
      resumeCnt_r <= 16'h0000;
    end else begin
      unique case (state_r)
        USPMC_ST_RUN: begin
          if (ctrl_r[CTRL_LOW_POWER] || usbSuspend) begin
            state_r <= USPMC_ST_LOW_POWER;
          end
        end
        USPMC_ST_LOW_POWER: begin
          if (wakeReq) begin
            if (usbSuspend && ctrl_r[CTRL_REMOTE_WAKE]) begin
              state_r <= USPMC_ST_RESUME;
              resumeCnt_r <= RESUME_CYCLES[15:0];
            end else if (!usbSuspend) begin
              state_r <= USPMC_ST_RUN;
            end
          end else if (!usbSuspend && !ctrl_r[CTRL_LOW_POWER]) begin
            state_r <= USPMC_ST_RUN;
          end
        end
        USPMC_ST_RESUME: begin
          if (resumeCnt_r == 16'h0001) begin
            state_r <= USPMC_ST_RUN;
          end
          resumeCnt_r <= resumeCnt_r - 16'h0001;
        end
        default: state_r <= USPMC_ST_RUN;
      endcase
    end
  end

  // trigger edge: one scan request per falling edge, none in low power
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigPrev_r <= 1'b1;
      scanStart <= 1'b0;
    end else begin
      trigPrev_r <= scan_start_in_n;
      scanStart <= trigPrev_r && !scan_start_in_n && state_r == USPMC_ST_RUN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins: lamps; the lamp is released whenever the light owns the shared pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      good_read_lamp_n <= 1'b1;
      external_light_ctrl <= 1'b1;
    end else begin
      good_read_lamp_n <= ctrl_r[CTRL_ILLUM_EN] || !ctrl_r[CTRL_GOOD_READ];
      external_light_ctrl <= !(ctrl_r[CTRL_ILLUM_EN] && ctrl_r[CTRL_GOOD_READ]);
    end
  end

  // aim input means wake in low power, so the aimer follows it only in run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aimerOn <= 1'b0;
      low_power_indicator <= 1'b0;
    end else begin
      aimerOn <= state_r == USPMC_ST_RUN && !aimer_wake_in_n;
      low_power_indicator <= state_r == USPMC_ST_LOW_POWER;
    end
  end

  // usb link status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usbFullSpeed <= 1'b0;
      usbSerialActive <= 1'b0;
      usbResume <= 1'b0;
    end else begin
      usbFullSpeed <= ifMode_r == USPMC_IF_USB_SERIAL;
      usbSerialActive <= ifMode_r == USPMC_IF_USB_SERIAL;
      usbResume <= state_r == USPMC_ST_RESUME;
    end
  end

  assign nvStore.ifMode = ifMode_r;
  assign nvStore.portPinned = portPinned_r;
  assign nvStoreReq = nvStoreReq_r;
  assign portPinnedActive = portPinnedLive_r;

  ////////////////////////////////////////////////////////////////////////////
  // read path; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        OFS_CTRL: rdata_r <= {24'h000000, ctrl_r};
        OFS_STATUS: rdata_r <= {24'h000000, portPinnedLive_r, state_r, portPinned_r,
                                ifMode_r, trigPrev_r, aimer_wake_in_n};
        OFS_BEEP_PERIOD: rdata_r <= {16'h0000, beepPeriod_r};
        OFS_BEEP_DUTY: rdata_r <= {16'h0000, beepDuty_r};
        OFS_NV_IMAGE: rdata_r <= {29'h00000000, portPinned_r, ifMode_r};
        default: rdata_r <= 32'h00000000;
      endcase
    end else begin
      rdata_r <= 32'h00000000;
    end
  end
  assign rdata = rdata_r;
endmodule // uspmc_mode_control

// file: logic/uspmc_pkg.sv
// package: codes, register offsets and timing for the usb serial mode control block
package uspmc_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_BEEP_PERIOD = 8'h0C;
  localparam logic [7:0] OFS_BEEP_DUTY = 8'h10;
  localparam logic [7:0] OFS_NV_IMAGE = 8'h14;
  // ctrl field positions
  localparam int CTRL_ILLUM_EN = 0;
  localparam int CTRL_BEEP_EN = 1;
  localparam int CTRL_GOOD_READ = 2;
  localparam int CTRL_WAKE_EN = 3;
  localparam int CTRL_LOW_POWER = 4;
  localparam int CTRL_REBOOT = 5;
  localparam int CTRL_REMOTE_WAKE = 6;
  // command codes written to the cmd register
  localparam logic [7:0] CMD_USB_SERIAL_SELECT = 8'h01;
  localparam logic [7:0] CMD_UART_SELECT = 8'h02;
  localparam logic [7:0] CMD_KEYBOARD_SELECT = 8'h03;
  localparam logic [7:0] CMD_PORT_FLOATING = 8'h10;
  localparam logic [7:0] CMD_PORT_PINNED = 8'h11;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [15:0] BEEP_PERIOD_RESET = 16'h2710;
  localparam logic [15:0] BEEP_DUTY_RESET = 16'h1388;
  // timing: remote wakeup resume signalling length
  localparam int CLK_HZ = 40000000;
  localparam int RESUME_US = 10;
  localparam int RESUME_CYC = (CLK_HZ / 1000000) * RESUME_US;
  typedef enum logic [1:0] {
    USPMC_IF_UART = 2'b00,
    USPMC_IF_USB_SERIAL = 2'b01,
    USPMC_IF_KEYBOARD = 2'b10
  } uspmc_if_t;
  typedef enum logic [1:0] {
    USPMC_ST_RUN = 2'b00,
    USPMC_ST_LOW_POWER = 2'b01,
    USPMC_ST_RESUME = 2'b10
  } uspmc_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } uspmc_bus_t;
  typedef struct packed {
    uspmc_if_t ifMode;
    logic portPinned;
  } uspmc_nv_t;
endpackage
